// file: verilog/swr_regs.vh
`ifndef SWR_REGS_VH
`define SWR_REGS_VH
// system clock rate and the internal timebase tick
`define SWR_CLK_KHZ 20000
`define SWR_TICK_MS 1
// internal timebase periods, in milliseconds
`define SWR_INT_WD_FAST_MS 13'd100
`define SWR_INT_WD_SLOW_MS 13'd1600
`define SWR_INT_WD_AFTER_MS 13'd1600
`define SWR_INT_RST_MS 13'd200
// external timebase periods, in timebase clocks
`define SWR_EXT_WD_CLKS 13'd1024
`define SWR_EXT_WD_AFTER_CLKS 13'd4096
`define SWR_EXT_RST_CLKS 13'd2048
// chip-select grace window after reset asserts
`define SWR_CE_GRACE_NS 15000
`define SWR_CLK_PERIOD_NS 50
`define SWR_CE_GRACE_CYC ((`SWR_CE_GRACE_NS) / (`SWR_CLK_PERIOD_NS))
// synchronised pin vector bit positions
`define SWR_PIN_VCC_OK 0
`define SWR_PIN_VCC_GT_BATT 1
`define SWR_PIN_PF_ABOVE 2
`define SWR_PIN_KICK_HI 3
`define SWR_PIN_KICK_LO 4
`define SWR_PIN_TB_SEL 5
`define SWR_PIN_TB_IN 6
`define SWR_PIN_CE_N 7
`define SWR_PIN_W 8
// reset value of the synchronised pins: chip select idle high, internal timebase
`define SWR_PIN_RST 8'ha0
`endif

// file: verilog/swr_sync.v
`default_nettype none
// three-stage synchroniser; the output follows only once stages two and three agree
module swr_sync #(
  parameter W = 8,
  parameter [W-1:0] RST_VAL = {W{1'b0}}
) (
  input wire clk_i,
  input wire srst_i,
  input wire [W-1:0] d_i,
  output reg [W-1:0] q_o
);
  reg [W-1:0] s1_reg;
  reg [W-1:0] s2_reg;
  reg [W-1:0] s3_reg;
  wire [W-1:0] q_next;
  genvar g;
  always @(posedge clk_i) begin
    if (srst_i) begin
      s1_reg <= RST_VAL;
      s2_reg <= RST_VAL;
      s3_reg <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      s1_reg <= d_i;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      q_o <= q_next;
    end
  end
  // a bit moves only once the last two stages agree, so a pin caught mid-change cannot pass
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      assign q_next[g] = (s2_reg[g] == s3_reg[g]) ? s3_reg[g] : q_o[g];
    end
  endgenerate
endmodule // swr_sync
`default_nettype wire

// file: verilog/swr_supervisor.v
// Contract
// - low-supply flag follows main supply comparator
// - switched supply selects main or backup source
// - backup-active high while on backup source
// - timebase select high picks internal oscillator
// - internal mode: timebase input picks watchdog period
// - external mode: periods counted in timebase clocks
// - power-fail flag mirrors comparator, no side effect
// - kick stuck beyond timeout: flag low, reset
// - timeout flag low until next kick transition
// - mid-level kick disables watchdog, flag high
// - chip-select passes only outside reset
// - chip-select grace until input high or 15us
// - reset on low supply, held after recovery
// - active-high reset is inverse of reset_n
// - each kick transition restarts watchdog count
// - internal fast mode: 100ms normal, 1.6s after reset
// - external clock: 1024, 4096, 2048 clock counts
// - stuck kick repeats reset pulses each period
`include "swr_regs.vh"
`default_nettype none
module swr_supervisor #(
  parameter TICK_CYCLES = `SWR_CLK_KHZ * `SWR_TICK_MS,
  parameter CE_GRACE_CYCLES = `SWR_CE_GRACE_CYC
) (
  input wire clk_i,
  input wire srst_i,
  input wire vcc_ok_i,
  input wire vcc_gt_backup_i,
  input wire powerfail_sense_above_i,
  input wire kick_input_high_i,
  input wire kick_input_low_i,
  input wire timebase_select_i,
  input wire timebase_input_i,
  input wire ce_n_i,
  output reg low_line_n_o,
  output reg switched_supply_backup_o,
  output reg backup_active_o,
  output reg powerfail_flag_n_o,
  output reg timeout_flag_n_o,
  output reg reset_n_o,
  output reg reset_o,
  output reg ce_n_o
);
  localparam ST_LOW = 2'd0;
  localparam ST_HOLD = 2'd1;
  localparam ST_RUN = 2'd2;

  ////////////////////////////////////////////////////////////////////////////
  wire [`SWR_PIN_W-1:0] pins;
  swr_sync #(
    .W(`SWR_PIN_W),
    .RST_VAL(`SWR_PIN_RST)
  ) u_sync (
    .clk_i(clk_i),
    .srst_i(srst_i),
    .d_i({ce_n_i, timebase_input_i, timebase_select_i, kick_input_low_i, kick_input_high_i,
          powerfail_sense_above_i, vcc_gt_backup_i, vcc_ok_i}),
    .q_o(pins)
  );
  wire vcc_ok = pins[`SWR_PIN_VCC_OK];
  wire tb_internal = pins[`SWR_PIN_TB_SEL];
  wire tb_in = pins[`SWR_PIN_TB_IN];
  wire ce_n = pins[`SWR_PIN_CE_N];
  wire [1:0] kick_lvl = {pins[`SWR_PIN_KICK_HI], pins[`SWR_PIN_KICK_LO]};
  wire kick_mid = (kick_lvl == 2'b00) || (kick_lvl == 2'b11);

  ////////////////////////////////////////////////////////////////////////////
  // timebase tick: 1 ms from the divider, or one per rising external timebase edge
  reg [15:0] div_reg;
  reg tb_prev_reg;
  wire div_end = (div_reg == TICK_CYCLES[15:0] - 16'h0001);
  wire ext_edge = tb_in && !tb_prev_reg;
  wire tick = tb_internal ? div_end : ext_edge;
  always @(posedge clk_i) begin
    if (srst_i) begin
      div_reg <= 16'h0000;
      tb_prev_reg <= 1'b0;
    end else begin
      div_reg <= div_end ? 16'h0000 : div_reg + 16'h0001;
      tb_prev_reg <= tb_in;
    end
  end

  // period selection; with the internal timebase, a low timebase input means the fast period
  wire [12:0] wd_normal = tb_internal ? (tb_in ? `SWR_INT_WD_SLOW_MS : `SWR_INT_WD_FAST_MS)
                                      : `SWR_EXT_WD_CLKS;
  wire [12:0] wd_after = tb_internal ? `SWR_INT_WD_AFTER_MS : `SWR_EXT_WD_AFTER_CLKS;
  wire [12:0] rst_len = tb_internal ? `SWR_INT_RST_MS : `SWR_EXT_RST_CLKS;

  ////////////////////////////////////////////////////////////////////////////
  reg [1:0] state_reg;
  reg [12:0] cnt_reg;
  reg after_reg;
  reg [1:0] kick_prev_reg;
  reg [15:0] grace_reg;
  reg grace_reg_on;
  wire kick_evt = !kick_mid && (kick_lvl != kick_prev_reg);
  wire [12:0] wd_lim = after_reg ? wd_after : wd_normal;
  wire wd_expire = (state_reg == ST_RUN) && !kick_mid && !kick_evt && tick &&
                   (cnt_reg + 13'd1 >= wd_lim);
  wire in_reset = (state_reg != ST_RUN);

  always @(posedge clk_i) begin
    if (srst_i) begin
      state_reg <= ST_LOW;
      cnt_reg <= 13'd0;
      after_reg <= 1'b1;
      kick_prev_reg <= 2'b00;
      timeout_flag_n_o <= 1'b1;
    end else begin
      kick_prev_reg <= kick_lvl;
      if (!vcc_ok) begin
        state_reg <= ST_LOW;
        cnt_reg <= 13'd0;
        after_reg <= 1'b1;
      end else begin
        case (state_reg)
          ST_LOW: begin
            state_reg <= ST_HOLD;
            cnt_reg <= 13'd0;
          end
          ST_HOLD: begin
            if (tick) begin
              if (cnt_reg + 13'd1 >= rst_len) begin
                state_reg <= ST_RUN;
                cnt_reg <= 13'd0;
                after_reg <= 1'b1;
              end else begin
                cnt_reg <= cnt_reg + 13'd1;
              end
            end
          end
          ST_RUN: begin
            if (kick_mid || kick_evt) begin
              cnt_reg <= 13'd0;
              if (kick_evt) begin
                after_reg <= 1'b0;
              end
            end else if (wd_expire) begin
              state_reg <= ST_HOLD;
              cnt_reg <= 13'd0;
            end else if (tick) begin
              cnt_reg <= cnt_reg + 13'd1;
            end
          end
          default: begin
            state_reg <= ST_LOW;
            cnt_reg <= 13'd0;
          end
        endcase
      end
      // the flag stays low through repeated pulses; a kick edge, a disabled watchdog or low supply lifts it
      if (!vcc_ok || kick_mid) begin
        timeout_flag_n_o <= 1'b1;
      end else if (wd_expire) begin
        timeout_flag_n_o <= 1'b0;
      end else if (kick_evt) begin
        timeout_flag_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip-select gating; a select already low when reset strikes may finish its cycle
  reg in_reset_prev_reg;
  always @(posedge clk_i) begin
    if (srst_i) begin
      in_reset_prev_reg <= 1'b1;
      grace_reg <= 16'h0000;
      grace_reg_on <= 1'b0;
      ce_n_o <= 1'b1;
    end else begin
      in_reset_prev_reg <= in_reset;
      if (in_reset && !in_reset_prev_reg && !ce_n) begin
        grace_reg_on <= 1'b1;
        grace_reg <= 16'h0000;
      end else if (grace_reg_on) begin
        if (ce_n || (grace_reg >= CE_GRACE_CYCLES[15:0] - 16'h0001) || !in_reset) begin
          grace_reg_on <= 1'b0;
        end else begin
          grace_reg <= grace_reg + 16'h0001;
        end
      end
      if (!in_reset) begin
        ce_n_o <= ce_n;
      end else if ((grace_reg_on && !ce_n) || (!in_reset_prev_reg && !ce_n)) begin
        ce_n_o <= 1'b0;
      end else begin
        ce_n_o <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge clk_i) begin
    if (srst_i) begin
      low_line_n_o <= 1'b0;
      switched_supply_backup_o <= 1'b0;
      backup_active_o <= 1'b0;
      powerfail_flag_n_o <= 1'b0;
      reset_n_o <= 1'b0;
      reset_o <= 1'b1;
    end else begin
      low_line_n_o <= vcc_ok;
      powerfail_flag_n_o <= pins[`SWR_PIN_PF_ABOVE];
      reset_n_o <= !in_reset;
      reset_o <= in_reset;
      // between the two switch points the source is held, which gives hysteresis
      if (vcc_ok && pins[`SWR_PIN_VCC_GT_BATT]) begin
        switched_supply_backup_o <= 1'b0;
        backup_active_o <= 1'b0;
      end else if (!vcc_ok && !pins[`SWR_PIN_VCC_GT_BATT]) begin
        switched_supply_backup_o <= 1'b1;
        backup_active_o <= 1'b1;
      end
    end
  end
endmodule // swr_supervisor
`default_nettype wire

// file: dv/swr_supervisor_properties.sv
`default_nettype none
module swr_supervisor_properties (
  input wire logic clk_i,
  input wire logic srst_i,
  input wire logic vcc_ok_i,
  input wire logic vcc_gt_backup_i,
  input wire logic powerfail_sense_above_i,
  input wire logic kick_input_high_i,
  input wire logic kick_input_low_i,
  input wire logic low_line_n_o,
  input wire logic switched_supply_backup_o,
  input wire logic powerfail_flag_n_o,
  input wire logic timeout_flag_n_o,
  input wire logic reset_n_o,
  input wire logic reset_o,
  input wire logic ce_n_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  ////////////////////////////////////////
  // eight-cycle runs cover the synchroniser and output flop latency
  property p_inv; reset_o != reset_n_o; endproperty
  a_inv: assert property (p_inv) else $error("reset outputs agree");
  property p_low; !vcc_ok_i [*8] |-> !low_line_n_o; endproperty
  a_low: assert property (p_low) else $error("low line flag high");
  property p_rst; !vcc_ok_i [*8] |-> !reset_n_o; endproperty
  a_rst: assert property (p_rst) else $error("no reset on low supply");
  property p_sup; (!vcc_ok_i && !vcc_gt_backup_i) [*8] |-> switched_supply_backup_o; endproperty
  a_sup: assert property (p_sup) else $error("supply not on backup");
  property p_pf; $stable(powerfail_sense_above_i) [*8] |-> powerfail_flag_n_o == powerfail_sense_above_i; endproperty
  a_pf: assert property (p_pf) else $error("power fail flag wrong");
  property p_mid; (kick_input_high_i == kick_input_low_i) [*8] |-> timeout_flag_n_o; endproperty
  a_mid: assert property (p_mid) else $error("flag low with kick floating");
  property p_ce; $fell(reset_n_o) |-> ##[0:305] ce_n_o; endproperty
  a_ce: assert property (p_ce) else $error("chip select not blocked");
  property p_wd; $fell(timeout_flag_n_o) |-> ##[0:2] !reset_n_o; endproperty
  a_wd: assert property (p_wd) else $error("timeout without reset");
endmodule // swr_supervisor_properties
bind swr_supervisor swr_supervisor_properties chk_u (
  .clk_i(clk_i),
  .srst_i(srst_i),
  .vcc_ok_i(vcc_ok_i),
  .vcc_gt_backup_i(vcc_gt_backup_i),
  .powerfail_sense_above_i(powerfail_sense_above_i),
  .kick_input_high_i(kick_input_high_i),
  .kick_input_low_i(kick_input_low_i),
  .low_line_n_o(low_line_n_o),
  .switched_supply_backup_o(switched_supply_backup_o),
  .powerfail_flag_n_o(powerfail_flag_n_o),
  .timeout_flag_n_o(timeout_flag_n_o),
  .reset_n_o(reset_n_o),
  .reset_o(reset_o),
  .ce_n_o(ce_n_o)
);
`default_nettype wire

// file: dv/swr_cpu_model.sv
`default_nettype none
module swr_cpu_model (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic [1:0] mode_i,
  output logic kick_high_o,
  output logic kick_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [6:0] cnt_reg = 7'h00;
  initial {kick_high_o, kick_low_o} = 2'h0;
  // mode 0 floats the pin, 1 kicks while out of reset, 2 hangs on one level
  always @(posedge clk_i) begin
    cnt_reg <= #1 cnt_reg + 7'h01;
    if (mode_i == 2'h0) begin
      {kick_high_o, kick_low_o} <= #1 2'h0;
    end else if (mode_i == 2'h1 && reset_n_i && cnt_reg == 7'h00) begin
      {kick_high_o, kick_low_o} <= #1 kick_high_o ? 2'h1 : 2'h2;
    end else if (kick_high_o == kick_low_o) begin
      {kick_high_o, kick_low_o} <= #1 2'h2;
    end
  end
endmodule // swr_cpu_model
`default_nettype wire

// file: dv/tb.sv
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic vcc_ok = 1'b0;
  logic vcc_gt = 1'b0;
  logic pf_in = 1'b0;
  logic ce_n = 1'b1;
  logic [1:0] mode = 2'h0;
  logic tb_sel = 1'b1;
  logic tb_lvl = 1'b0;
  logic tb_in = 1'b0;
  logic [1:0] tb_div = 2'h0;
  logic k_hi, k_lo, low_n, sw_bk, bk_act, pf_n, flag_n, rst_n, rst, ce_out;
  int errors = 0;
  int checked = 0;
  swr_supervisor #(.TICK_CYCLES(4)) dut_u (.clk_i(clk_i), .srst_i(srst_i), .vcc_ok_i(vcc_ok),
    .vcc_gt_backup_i(vcc_gt), .powerfail_sense_above_i(pf_in), .kick_input_high_i(k_hi),
    .kick_input_low_i(k_lo), .timebase_select_i(tb_sel), .timebase_input_i(tb_in), .ce_n_i(ce_n),
    .low_line_n_o(low_n), .switched_supply_backup_o(sw_bk), .backup_active_o(bk_act),
    .powerfail_flag_n_o(pf_n), .timeout_flag_n_o(flag_n), .reset_n_o(rst_n), .reset_o(rst), .ce_n_o(ce_out));
  swr_cpu_model cpu_u (.clk_i(clk_i), .reset_n_i(rst_n), .mode_i(mode), .kick_high_o(k_hi), .kick_low_o(k_lo));
  initial forever #25 clk_i = ~clk_i;
  // the external timebase runs at a quarter of the clock, so one tick is four clocks in both modes
  always @(posedge clk_i) begin
    tb_div <= #1 tb_div + 2'h1;
    tb_in <= #1 tb_sel ? tb_lvl : tb_div[1];
  end
  ////////////////////////////////////////
  task automatic check(input logic seen, input logic exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  task automatic finish_test;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // one tick is 4 clocks: reset hold 800, fast period 400, after-reset 6400
  task automatic t_power;
    {vcc_ok, vcc_gt, pf_in} = 3'h7;
    cyc(10);
    check(low_n, 1'b1);
    check(bk_act | sw_bk, 1'b0);
    cyc(760);
    check(rst_n, 1'b0);
    check(rst, 1'b1);
    cyc(50);
    check(rst_n, 1'b1);
  endtask
  task automatic t_pfail;
    pf_in = 1'b0;
    cyc(10);
    check(pf_n, 1'b0);
    check(rst_n, 1'b1);
    pf_in = 1'b1;
  endtask
  task automatic t_watchdog;
    mode = 2'h1;
    cyc(1000);
    check(flag_n & rst_n, 1'b1);
    mode = 2'h2;
    cyc(250);
    check(flag_n, 1'b1);
    cyc(170);
    check(flag_n | rst_n, 1'b0);
    cyc(900);
    check(rst_n, 1'b1);
    check(flag_n, 1'b0);
    cyc(6400);
    check(rst_n, 1'b0);
    mode = 2'h1;
    cyc(1000);
    check(flag_n & rst_n, 1'b1);
    mode = 2'h0;
    cyc(7000);
    check(flag_n & rst_n, 1'b1);
  endtask
  task automatic t_chip_sel;
    ce_n = 1'b0;
    cyc(10);
    check(ce_out, 1'b0);
    vcc_ok = 1'b0;
    cyc(10);
    check(low_n | rst_n | ce_out, 1'b0);
    cyc(310);
    check(ce_out, 1'b1);
    vcc_gt = 1'b0;
    cyc(10);
    check(bk_act & sw_bk, 1'b1);
  endtask
  // slow internal period: a hang survives well past the fast period, then times out near 6400
  task automatic t_slow;
    tb_lvl = 1'b1;
    mode = 2'h1;
    cyc(200);
    mode = 2'h2;
    cyc(3000);
    check(flag_n & rst_n, 1'b1);
    cyc(3400);
    check(flag_n | rst_n, 1'b0);
    mode = 2'h1;
    cyc(1000);
    check(flag_n & rst_n, 1'b1);
    mode = 2'h0;
    tb_lvl = 1'b0;
  endtask
  // external timebase: reset 2048, normal 1024, after-reset 4096 clocks of four cycles each
  task automatic t_ext;
    tb_sel = 1'b0;
    mode = 2'h1;
    {vcc_ok, vcc_gt} = 2'h3;
    cyc(8100);
    check(rst_n, 1'b0);
    check(ce_out, 1'b1);
    check(bk_act | sw_bk, 1'b0);
    cyc(200);
    check(rst_n, 1'b1);
    check(ce_out, 1'b0);
    ce_n = 1'b1;
    cyc(500);
    mode = 2'h2;
    cyc(3800);
    check(flag_n, 1'b1);
    cyc(400);
    check(flag_n | rst_n, 1'b0);
    cyc(8300);
    check(rst_n, 1'b1);
    check(flag_n, 1'b0);
    cyc(4500);
    check(rst_n, 1'b1);
    cyc(11800);
    check(rst_n, 1'b0);
  endtask
  initial begin
    cyc(16);
    srst_i = 1'b0;
    t_power();
    t_pfail();
    t_watchdog();
    t_slow();
    t_chip_sel();
    t_ext();
    finish_test();
  end
  initial begin
    repeat (80000) @(posedge clk_i);
    errors++;
    finish_test();
  end
endmodule // tb
`default_nettype wire
